// ===== phyp_pkg.sv
package phyp_pkg;

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int         CFG_GATE    = 0;

  // Status field positions.
  localparam int ST_AUTONEG = 0;
  localparam int ST_MODE_LO = 1;
  localparam int ST_MGMT    = 4;
  localparam int ST_IDLE_HI = 5;
  localparam int ST_LINK_LO = 8;
  localparam int ST_IRQ     = 12;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam logic [2:0] RX_TAIL_CLKS = 3'h5;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic {PHYP_SETTLE, PHYP_RUN} phyp_strap_e;

endpackage

// ===== phyp_rx_if.sv
`timescale 1ns/1ps
// Signals between the pin logic and one receive port.
interface phyp_rx_if;
  logic carrier;
  logic data;
  logic gate_cont;
  logic idle_high;
  logic rx_clk;
  logic sense;
  logic rxd;
  modport port (input carrier, data, gate_cont, idle_high, output rx_clk, sense, rxd);
  modport ctl  (output carrier, data, gate_cont, idle_high, input rx_clk, sense, rxd);
endinterface

// ===== phyp_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser; only the second stage is read outside.
module phyp_sync
  import phyp_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  // The first stage feeds the second stage alone.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ===== phyp_rx_port.sv
`timescale 1ns/1ps
// One receive port on the oscillator clock: halves it into the receive clock.
module phyp_rx_port
  import phyp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  phyp_rx_if.port   rx
);

  logic [2:0] tail;
  wire        run;
  wire        next_clk;
  wire  [2:0] next_tail;

  // The clock keeps toggling while carrier, tail or continuous mode hold it.
  assign run       = rx.sense | rx.gate_cont | (tail != 3'h0);
  assign next_clk  = run & ~rx.rx_clk;
  assign next_tail = rx.sense ? RX_TAIL_CLKS :
                     (next_clk && tail != 3'h0) ? tail - 3'h1 : tail;

  // Data changes on the falling clock edge so it is steady at the rising one.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx.rx_clk <= 1'b0;
      rx.sense  <= 1'b0;
      rx.rxd    <= 1'b0;
      tail      <= 3'h0;
    end
    else
    begin
      rx.rx_clk <= next_clk;
      rx.sense  <= rx.carrier;
      tail      <= next_tail;
      if (rx.rx_clk)
        rx.rxd <= rx.sense ? rx.data : rx.idle_high;
    end
  end

  sequence s_tail_done;
    !rx.sense && !rx.gate_cont && tail == 3'h0;
  endsequence

  property p_clk_toggle;
    @(posedge clk) disable iff (!rst_n)
    rx.sense |=> (rx.rx_clk != $past(rx.rx_clk));
  endproperty
  a_clk_toggle: assert property (p_clk_toggle) else $error("rx clock not toggling");

  property p_gate_stop;
    @(posedge clk) disable iff (!rst_n)
    s_tail_done ##0 !rx.rx_clk |=> !rx.rx_clk;
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("rx clock ran past tail");

  property p_tail_load;
    @(posedge clk) disable iff (!rst_n)
    rx.sense |=> tail == RX_TAIL_CLKS;
  endproperty
  a_tail_load: assert property (p_tail_load) else $error("tail count not loaded");

  property p_data_stable;
    @(posedge clk) disable iff (!rst_n)
    !rx.rx_clk |=> $stable(rx.rxd);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("rxd moved at rise");

  property p_idle_level;
    @(posedge clk) disable iff (!rst_n)
    rx.rx_clk && !rx.sense |=> rx.rxd == $past(rx.idle_high);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("wrong idle level");

endmodule

// ===== phyp_top.sv
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Controller-side pin logic of a four-port transceiver.
module phyp_top
  import phyp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        oscillator_in,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  rx_line_carrier,
  input  wire logic [3:0]  rx_line_data,
  output logic      [3:0]  recovered_rx_clock,
  output logic      [3:0]  carrier_sense_out,
  input  wire logic [3:0]  rx_data_in,
  output logic      [3:0]  rx_data_out,
  output logic      [3:0]  rx_data_oe,
  input  wire logic        mgmt_strap_in,
  input  wire logic        mdc_loop_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             int_out,
  output logic             int_oe,
  input  wire logic        link_1_in,
  output logic             link_1_out,
  output logic             link_1_oe,
  output logic             link_2_out,
  input  wire logic [3:0]  link_lost,
  input  wire logic [3:0]  jabber,
  input  wire logic        mgmt_data_out,
  input  wire logic        mgmt_data_oe,
  input  wire logic        mgmt_int_ack,
  output logic             mgmt_data_in,
  output logic             mgmt_clk_rise,
  output logic      [3:0]  loopback_request,
  output logic             mgmt_enable,
  output logic             autoneg_enable,
  output logic      [2:0]  mac_if_mode,
  output logic             rx_idle_high
);

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic [3:0] strap_rxd;
  logic       strap_mgmt;
  logic       strap_link1;
  logic       mdc_s;
  logic       mdio_s;

  // Straps and pins come from outside, so each passes two flops first.
  phyp_sync #(.W(8)) u_pin_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({rx_data_in, mgmt_strap_in, link_1_in, mdc_loop_in, mdio_in}),
    .q     ({strap_rxd, strap_mgmt, strap_link1, mdc_s, mdio_s})
  );

  // ----------------------------------------------------------------
  // Strap capture.
  // ----------------------------------------------------------------
  phyp_strap_e state;
  logic [1:0]  settle;
  wire         latch_now;

  // Flops cannot take pin levels under reset, so straps are caught once
  // the synchronisers have filled after release.
  assign latch_now = (state == PHYP_SETTLE) && (settle == STRAP_SETTLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state  <= PHYP_SETTLE;
      settle <= 2'h0;
    end
    else
    begin
      case (state)
        PHYP_SETTLE:
        begin
          settle <= settle + 2'h1;
          if (latch_now)
            state <= PHYP_RUN;
        end
        PHYP_RUN:
          state <= PHYP_RUN;
        default:
          state <= PHYP_SETTLE;
      endcase
    end
  end

  // Strap values are written once and then held until the next reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      autoneg_enable <= 1'b1;
      mac_if_mode    <= 3'h7;
      mgmt_enable    <= 1'b1;
      rx_idle_high   <= 1'b0;
    end
    else if (latch_now)
    begin
      autoneg_enable <= strap_rxd[3];
      mac_if_mode    <= strap_rxd[2:0];
      mgmt_enable    <= strap_mgmt;
      rx_idle_high   <= ~strap_link1;
    end
  end

  // ----------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------
  logic        cfg_gate_cont;
  logic        irq_pend;
  wire         apb_setup;
  wire         apb_done;
  wire         hit_cfg;
  wire         hit_status;
  wire  [31:0] status_word;
  wire  [31:0] rd_word;

  // Every access takes one wait state so that read data comes from a flop.
  assign apb_setup  = psel & penable & ~pready;
  assign apb_done   = psel & penable & pready;
  assign hit_cfg    = (paddr == ADDR_CFG);
  assign hit_status = (paddr == ADDR_STATUS);

  assign status_word = (32'(autoneg_enable) << ST_AUTONEG)
                     | (32'(mac_if_mode) << ST_MODE_LO)
                     | (32'(mgmt_enable) << ST_MGMT)
                     | (32'(rx_idle_high) << ST_IDLE_HI)
                     | (32'(link_lost) << ST_LINK_LO)
                     | (32'(irq_pend) << ST_IRQ);

  assign rd_word = hit_cfg    ? (32'(cfg_gate_cont) << CFG_GATE) :
                   hit_status ? status_word : 32'h0000_0000;

  // Answer flops for the bus.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apb_setup;
      if (apb_setup)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~(hit_cfg | hit_status) | (pwrite & hit_status);
      end
    end
  end

  // Gating selection: zero stops the clock five cycles after carrier.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_gate_cont <= 1'b0;
    else if (apb_done && pwrite && hit_cfg)
      cfg_gate_cont <= pwdata[CFG_GATE];
  end

  // ----------------------------------------------------------------
  // Shared management pins.
  // ----------------------------------------------------------------
  logic [3:0] link_prev;
  logic       mdc_prev;
  wire        irq_event;

  // An event in the acknowledge cycle survives: set wins over clear.
  assign irq_event = (|(link_lost ^ link_prev)) | (|jabber);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_prev <= 4'h0;
      irq_pend  <= 1'b0;
      mdc_prev  <= 1'b0;
    end
    else
    begin
      link_prev <= link_lost;
      mdc_prev  <= mdc_s;
      if (irq_event)
        irq_pend <= 1'b1;
      else if (mgmt_int_ack)
        irq_pend <= 1'b0;
    end
  end

  // Pin drivers; every shared pin stays released until straps are caught.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mdio_out         <= 1'b0;
      mdio_oe          <= 1'b0;
      int_out          <= 1'b0;
      int_oe           <= 1'b0;
      link_1_out       <= 1'b0;
      link_1_oe        <= 1'b0;
      link_2_out       <= 1'b0;
      loopback_request <= 4'h0;
      mgmt_data_in     <= 1'b0;
      mgmt_clk_rise    <= 1'b0;
      rx_data_oe       <= 4'h0;
    end
    else
    begin
      link_2_out    <= link_lost[1];
      link_1_out    <= link_lost[0];
      link_1_oe     <= (state == PHYP_RUN);
      rx_data_oe    <= {4{state == PHYP_RUN}};
      mgmt_data_in  <= mdio_s;
      mgmt_clk_rise <= mgmt_enable & mdc_s & ~mdc_prev;
      loopback_request <= {4{~mgmt_enable & mdc_s}};
      if (state != PHYP_RUN)
      begin
        mdio_oe <= 1'b0;
        int_oe  <= 1'b0;
      end
      else if (mgmt_enable)
      begin
        mdio_out <= mgmt_data_out;
        mdio_oe  <= mgmt_data_oe;
        int_out  <= 1'b0;
        int_oe   <= irq_pend;
      end
      else
      begin
        mdio_out <= link_lost[3];
        mdio_oe  <= 1'b1;
        int_out  <= link_lost[2];
        int_oe   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive ports on the oscillator clock.
  // ----------------------------------------------------------------
  logic [1:0] link_cfg;
  logic       link_rst_n;

  // Reset leaves the link domain only in step with its own clock.
  phyp_sync #(.W(1)) u_rst_sync
  (
    .clk   (oscillator_in),
    .rst_n (presetn),
    .d     (1'b1),
    .q     (link_rst_n)
  );

  // Static settings cross as levels.
  phyp_sync #(.W(2)) u_cfg_sync
  (
    .clk   (oscillator_in),
    .rst_n (presetn),
    .d     ({cfg_gate_cont, rx_idle_high}),
    .q     (link_cfg)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_port
      phyp_rx_if rxi ();
      assign rxi.carrier           = rx_line_carrier[g];
      assign rxi.data              = rx_line_data[g];
      assign rxi.gate_cont         = link_cfg[1];
      assign rxi.idle_high         = link_cfg[0];
      assign recovered_rx_clock[g] = rxi.rx_clk;
      assign carrier_sense_out[g]  = rxi.sense;
      assign rx_data_out[g]        = rxi.rxd;
      phyp_rx_port u_port
      (
        .clk   (oscillator_in),
        .rst_n (link_rst_n),
        .rx    (rxi.port)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  property p_strap_hold;
    @(posedge pclk) disable iff (!presetn)
    state == PHYP_RUN |=> $stable({autoneg_enable, mac_if_mode, mgmt_enable, rx_idle_high});
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

  property p_strap_oe;
    @(posedge pclk) disable iff (!presetn)
    state == PHYP_SETTLE |=> rx_data_oe == 4'h0;
  endproperty
  a_strap_oe: assert property (p_strap_oe) else $error("rxd driven in strap");

  property p_loopback;
    @(posedge pclk) disable iff (!presetn)
    !mgmt_enable && mdc_s |=> loopback_request == 4'hf;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback missing");

  property p_mdio_link4;
    @(posedge pclk) disable iff (!presetn)
    state == PHYP_RUN && !mgmt_enable |=> mdio_oe && mdio_out == $past(link_lost[3]);
  endproperty
  a_mdio_link4: assert property (p_mdio_link4) else $error("mdio link4 wrong");

  property p_int_low;
    @(posedge pclk) disable iff (!presetn)
    state == PHYP_RUN && mgmt_enable && irq_pend |=> int_oe && !int_out;
  endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt not low");

  property p_int_link3;
    @(posedge pclk) disable iff (!presetn)
    state == PHYP_RUN && !mgmt_enable |=> int_oe && int_out == $past(link_lost[2]);
  endproperty
  a_int_link3: assert property (p_int_link3) else $error("int link3 wrong");

  // The release edge itself still loads reset values, so it starts no attempt.
  property p_link12;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> link_2_out == $past(link_lost[1]) && link_1_out == $past(link_lost[0]);
  endproperty
  a_link12: assert property (p_link12) else $error("link 1/2 wrong");

  property p_mdc_edge;
    @(posedge pclk) disable iff (!presetn)
    mgmt_enable && $rose(mdc_s) |=> mgmt_clk_rise ##1 !mgmt_clk_rise;
  endproperty
  a_mdc_edge: assert property (p_mdc_edge) else $error("mdc edge lost");

endmodule

// ===== phyp_mac_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Receiving controller seen from one port.
// ----------------------------------------------------------------
module phyp_mac_model
(
  input  wire logic        rst_n,
  input  wire logic        rx_clk,
  input  wire logic        sense,
  input  wire logic        rxd,
  output logic             dbit,
  output logic             ibit,
  output logic      [7:0]  tail,
  output logic      [31:0] per
);
  realtime t0;

  // Everything is taken on the rising receive clock edge. The bench never lets
  // carrier sense fall on that edge, so the tail count cannot race.
  always @(posedge rx_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tail <= 8'h00;
      t0 = 0.0;
    end
    else
    begin
      per <= $rtoi($realtime - t0);
      t0 = $realtime;
      if (sense)
      begin
        dbit <= rxd;
        tail <= 8'h00;
      end
      else
      begin
        ibit <= rxd;
        tail <= tail + 8'h01;
      end
    end
  end
endmodule

// ===== phy_mac_pin_function_logic_tb.sv
`timescale 1ns/1ps
module phy_mac_pin_function_logic_tb
  import phyp_pkg::*;
;
  localparam int OSC_P = 12;
  localparam int CEIL  = 3000;
  logic        pclk = 1'b0, osc = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, per, d;
  logic [3:0]  carrier = 4'h0, ldata = 4'h0, rclk, csense, rxd_out, rxd_oe, rxd_pin, loop_req;
  logic [3:0]  strap = 4'hf, sv, ll, link_lost = 4'h0, jabber = 4'h0;
  logic        mstrap = 1'b1, mdc = 1'b0, stn = 1'b0, mdio_pin, mdio_out, mdio_oe, b;
  logic        int_out, int_oe, int_pin, l1_strap = 1'b1, l1_pin, l1_out, l1_oe, l2_out;
  logic        md_out = 1'b0, md_oe = 1'b0, ack = 1'b0, md_in, mrise, men, aneg, idle;
  logic        mclk, mcrs, mrxd, dbit, ibit;
  logic [2:0]  mode;
  logic [7:0]  tail;
  int          fp = 0, seed = 67126, failures = 0, checks = 0, cyc = 0, rises = 0, r0;
  logic [31:0] q_exp[$];
  int          q_sel[$];
  string       q_nm[$];
  logic [33:0] q_apb[$];

  // Shared pins resolve from every driver; released lines fall to their pull level.
  assign rxd_pin  = (rxd_oe & rxd_out) | (~rxd_oe & strap);
  assign l1_pin   = l1_oe ? l1_out : l1_strap;
  assign mdio_pin = mdio_oe ? mdio_out : stn;
  assign int_pin  = int_oe ? int_out : 1'b1;
  assign mclk     = rclk[fp];
  assign mcrs     = csense[fp];
  assign mrxd     = rxd_out[fp];

  // The oscillator is offset so its edges never meet those of pclk.
  always #50 pclk = ~pclk;
  initial
  begin
    #3.3;
    forever #(OSC_P / 2) osc = ~osc;
  end

  phyp_top i_phyp_top (.pclk(pclk), .presetn(presetn), .oscillator_in(osc), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line_carrier(carrier), .rx_line_data(ldata),
    .recovered_rx_clock(rclk), .carrier_sense_out(csense), .rx_data_in(rxd_pin),
    .rx_data_out(rxd_out), .rx_data_oe(rxd_oe), .mgmt_strap_in(mstrap), .mdc_loop_in(mdc),
    .mdio_in(mdio_pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .int_out(int_out),
    .int_oe(int_oe), .link_1_in(l1_pin), .link_1_out(l1_out), .link_1_oe(l1_oe),
    .link_2_out(l2_out), .link_lost(link_lost), .jabber(jabber), .mgmt_data_out(md_out),
    .mgmt_data_oe(md_oe), .mgmt_int_ack(ack), .mgmt_data_in(md_in), .mgmt_clk_rise(mrise),
    .loopback_request(loop_req), .mgmt_enable(men), .autoneg_enable(aneg), .mac_if_mode(mode),
    .rx_idle_high(idle));

  phyp_mac_model i_phyp_mac_model (.rst_n(presetn), .rx_clk(mclk), .sense(mcrs), .rxd(mrxd),
    .dbit(dbit), .ibit(ibit), .tail(tail), .per(per));

  function automatic logic [31:0] obs(int s);
    case (s)
      0: obs = {26'h0, idle, men, mode, aneg};
      1: obs = {23'h0, mdio_oe, int_pin, mdio_pin, l2_out, l1_out, loop_req};
      2: obs = {31'h0, md_in};
      3: obs = rises;
      4: obs = {30'h0, dbit, ibit};
      5: obs = {24'h0, tail};
      6: obs = {31'h0, tail > 8'h05};
      8: obs = {27'h0, rxd_oe, l1_oe};
      default: obs = per;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp_pin(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_apb(logic [33:0] e, logic [32:0] g);
    checks++;
    if (e[33] ? (g !== e[32:0]) : (g[32] !== e[32]))
    begin
      failures++;
      $display("[FAIL] apb expected %h seen %h", e[32:0], g);
    end
  endtask

  task automatic expect_pin(string nm, int s, logic [31:0] e);
    q_nm.push_back(nm);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask

  // Pin notes are settled mid-cycle, half a period after registered outputs move.
  always @(negedge pclk)
    while (q_sel.size() > 0)
      cmp_pin(q_nm.pop_front(), q_exp.pop_front(), obs(q_sel.pop_front()));

  // Bus answers are taken at the very edge where pready is sampled high.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && q_apb.size() > 0)
      cmp_apb(q_apb.pop_front(), {pslverr, prdata});

  // Management clock rises counted, plus a cycle ceiling against hangs.
  always @(posedge pclk)
  begin
    cyc++;
    if (mrise === 1'b1)
      rises++;
    if (cyc == CEIL)
    begin
      failures++;
      test_done();
    end
  end

  // The expected answer is {read, error, data}; a write checks only the error.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd, logic [33:0] e);
    @(posedge pclk);
    q_apb.push_back(e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset with fresh straps, then move every strap to show the latch holds.
  task automatic rst(logic m, logic l1);
    sv = 4'($random(seed));
    presetn <= 1'b0;
    strap <= sv;
    mstrap <= m;
    l1_strap <= l1;
    mdc <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    expect_pin("oe off", 8, 32'h0);
    repeat (6) @(posedge pclk);
    expect_pin("straps", 0, {26'h0, ~l1, m, sv[2:0], sv[3]});
    mstrap <= ~m;
    strap <= ~sv;
    l1_strap <= ~l1;
    repeat (6) @(posedge pclk);
    expect_pin("held", 0, {26'h0, ~l1, m, sv[2:0], sv[3]});
    expect_pin("oe on", 8, 32'h1f);
  endtask

  // Carrier drops just after a receive clock rise, so sense falls on a low phase.
  task automatic frame(logic v);
    fp = $unsigned($random(seed)) % 4;
    @(posedge osc);
    ldata[fp] <= v;
    carrier[fp] <= 1'b1;
    repeat (20) @(posedge osc);
    @(posedge mclk);
    carrier[fp] <= 1'b0;
    repeat (30) @(posedge osc);
    ldata[fp] <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse_ack();
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  initial
  begin
    rst(1'b1, 1'b1);
    frame(1'b1);
    expect_pin("tail", 5, {29'h0, RX_TAIL_CLKS});
    expect_pin("bits", 4, 32'h2);
    $display("test straps and gated clock done");
    d = $random(seed);
    apb(1'b1, ADDR_CFG, d | 32'h1, {2'b00, 32'h0});
    apb(1'b0, ADDR_CFG, 32'h0, {2'b10, 32'h1});
    apb(1'b1, ADDR_STATUS, d, {2'b01, 32'h0});
    apb(1'b0, 8'h08, d, {2'b11, 32'h0});
    frame(1'b1);
    expect_pin("run", 6, 32'h1);
    expect_pin("period", 7, 2 * OSC_P);
    $display("test bus and free clock done");
    r0 = rises;
    repeat (3)
    begin
      mdc <= 1'b1;
      repeat (2) @(posedge pclk);
      mdc <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    b = 1'($random(seed));
    stn <= b;
    link_lost <= 4'h3;
    mdc <= 1'b1;
    repeat (6) @(posedge pclk);
    expect_pin("mdc", 3, r0 + 4);
    expect_pin("mdio in", 2, {31'h0, b});
    expect_pin("pins", 1, {23'h0, 2'b00, b, 2'b11, 4'h0});
    pulse_ack();
    expect_pin("pins", 1, {23'h0, 2'b01, b, 2'b11, 4'h0});
    jabber[$unsigned($random(seed)) % 4] <= 1'b1;
    @(posedge pclk);
    jabber <= 4'h0;
    repeat (4) @(posedge pclk);
    expect_pin("pins", 1, {23'h0, 2'b00, b, 2'b11, 4'h0});
    pulse_ack();
    md_oe <= 1'b1;
    md_out <= ~b;
    repeat (5) @(posedge pclk);
    expect_pin("pins", 1, {23'h0, 2'b11, ~b, 2'b11, 4'h0});
    apb(1'b0, ADDR_STATUS, 32'h0, {2'b10, 20'h0, 4'h3, 4'h1, sv[2:0], sv[3]});
    $display("test management on done");
    md_oe <= 1'b0;
    rst(1'b0, 1'b0);
    apb(1'b0, ADDR_CFG, 32'h0, {2'b10, 32'h0});
    frame(1'b0);
    expect_pin("tail", 5, {29'h0, RX_TAIL_CLKS});
    expect_pin("bits", 4, 32'h1);
    ll = 4'($random(seed));
    link_lost <= ll;
    jabber <= 4'hf;
    mdc <= 1'b1;
    repeat (6) @(posedge pclk);
    expect_pin("pins", 1, {23'h1, ll[2], ll[3], ll[1], ll[0], 4'hf});
    mdc <= 1'b0;
    repeat (6) @(posedge pclk);
    expect_pin("pins", 1, {23'h1, ll[2], ll[3], ll[1], ll[0], 4'h0});
    @(posedge pclk);
    $display("test management off done");
    test_done();
  end
endmodule
